/* core/fpc_irr_bit.sv */
// Module: one interrupt request summary bit with read clear
`timescale 1ns/1ps
module fpc_irr_bit
  import fpc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Control
  input  wire logic seq_clear,
  input  wire logic event_in,
  input  wire logic status_read,
  // Result
  output logic      req_bit
);

  typedef struct packed
  {
    logic req;
  } fpc_bit_state_t;

  fpc_bit_state_t st_reg;
  fpc_bit_state_t st_next;

  // Event wins over a same-cycle status read
  always_comb
  begin
    st_next = st_reg;
    if (seq_clear)
      st_next.req = 1'b0;
    else if (event_in)
      st_next.req = 1'b1;
    else if (status_read)
      st_next.req = 1'b0;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      st_reg <= '0;
    else if (clk_en)
      st_reg <= st_next;
  end

  assign req_bit = st_reg.req;

endmodule

/* core/fpc_pkg.sv */
// Package: constants and carrier types for the framer primary control block
package fpc_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [8:0] FPC_ADDR_CTRL = 9'h001;
  localparam logic [8:0] FPC_ADDR_IRR  = 9'h003;
  localparam logic [8:0] FPC_ADDR_ISR0 = 9'h004;
  localparam logic [8:0] FPC_ADDR_ISR7 = 9'h00b;
  localparam int         FPC_BIT_RESET = 7;
  localparam int         FPC_BIT_INCF  = 5;
  localparam int         FPC_MODE_LSB  = 1;
  localparam int         FPC_BIT_RATE  = 0;
  localparam logic [7:0] FPC_CTRL_WMASK = 8'h3f;
  localparam logic [7:0] FPC_CTRL_DEF  = 8'h00;
  localparam logic [7:0] FPC_IRR_DEF   = 8'h00;
  localparam int         FPC_NGRP      = 8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int FPC_CLK_MHZ     = 200;
  localparam int FPC_RST_MAX_US  = 15;
  // Longest time in cycles; the sequence runs for exactly this many cycles unless the reset pin restarts the count
  localparam int FPC_RST_CYC     = FPC_RST_MAX_US * FPC_CLK_MHZ;
  localparam logic [11:0] FPC_RST_LAST = 12'(FPC_RST_CYC - 1);

  // ****************************************************************
  // Receive framer modes
  // ****************************************************************
  typedef enum logic [3:0]
  {
    FPC_T1_FT      = 4'h0,
    FPC_T1_ESF_FPS = 4'h1,
    FPC_T1_SF      = 4'h4,
    FPC_T1_SF_JYA  = 4'h5,
    FPC_T1_SF_DM   = 4'h6,
    FPC_T1_SLC_LOF = 4'h8,
    FPC_T1_SLC     = 4'h9,
    FPC_T1_ESF_MIM = 4'hc,
    FPC_T1_ESF_FRC = 4'hd
  } fpc_t1_mode_t;

  typedef enum logic [1:0]
  {
    FPC_ST_IDLE = 2'b00,
    FPC_ST_RUN  = 2'b01
  } fpc_state_t;

  // Decoded framer configuration handed to the synchronizer
  typedef struct packed
  {
    logic       t1_mode;
    logic       crc_fbit_include;
    logic       e1_cas_mf;
    logic       e1_crc_mf;
    logic       bit_slip_handling;
    logic       t1_sf;
    logic       t1_esf;
    logic       t1_esf_crc_check;
    logic       t1_esf_force_crc;
    logic       t1_slc;
    logic       slc_frame_loss_option;
    logic       japan_yellow_alarm;
    logic       t1_dm;
    logic [3:0] rx_framer_mode_sel;
    logic [3:0] loss_of_frame_thresholds;
  } fpc_cfg_t;

  // Host port request
  typedef struct packed
  {
    logic       rd;
    logic       wr;
    logic [8:0] addr;
    logic [7:0] wdata;
  } fpc_req_t;

endpackage

/* core/fpc_top.sv */
// Module: framer primary control register and interrupt request summary
`timescale 1ns/1ps
module fpc_top
  import fpc_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 clk_en,
  input  wire logic                 ext_reset_pin_n,
  input  wire logic                 global_reset_cmd,
  // Host register port
  input  wire fpc_pkg::fpc_req_t    host_req,
  output logic [7:0]                host_rdata,
  // Status group events and enables
  input  wire logic [7:0]           interrupt_status_group,
  input  wire logic                 master_interrupt_enable,
  input  wire logic [3:0]           loss_of_frame_thresholds,
  // Status register clear strobes
  output logic [7:0]                status_clear,
  // Framer configuration and reset state
  output fpc_pkg::fpc_cfg_t         framer_cfg,
  output logic                      framer_reset_active,
  // System bus output enables and programmable I/O direction
  output logic                      rx_signaling_out_oe,
  output logic                      rx_pcm_out_oe,
  output logic                      signaling_freeze_out_oe,
  output logic [7:0]                pio_dir_out,
  // Interrupts
  output logic                      master_interrupt_flag,
  output logic                      irq_out_n
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic [2:0]  pin_sync;
    fpc_state_t  state;
    logic [11:0] cnt;
    logic [7:0]  ctrl;
    logic [7:0]  rdata;
    logic [7:0]  sclr;
    fpc_cfg_t    cfg;
    logic        busy;
    logic        drive_en;
    logic [7:0]  pio_dir;
    logic        mflag;
    logic        irq_n;
  } fpc_top_state_t;

  fpc_top_state_t st_reg;
  fpc_top_state_t st_next;
  logic [7:0]     irr;
  logic [7:0]     isr_rd;
  logic           seq_clear;
  logic           pin_rst;
  logic           ctrl_wr;
  logic [3:0]     mode;
  logic           t1;

  assign t1      = st_reg.ctrl[FPC_BIT_RATE];
  assign mode    = st_reg.ctrl[FPC_MODE_LSB +: 4];
  assign ctrl_wr = host_req.wr && host_req.addr == FPC_ADDR_CTRL;
  // Second and third stages agree the pin is low
  assign pin_rst = !st_reg.pin_sync[1] && !st_reg.pin_sync[2];
  // Registers clear while the sequence is running
  assign seq_clear = st_reg.state == FPC_ST_RUN;

  // ****************************************************************
  // Interrupt request summary bits
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < FPC_NGRP; g++)
    begin : g_irr
      assign isr_rd[g] = host_req.rd
        && host_req.addr == 9'(FPC_ADDR_ISR0 + 9'(g));
      fpc_irr_bit u_bit
      (
        .core_clk    (core_clk),
        .reset       (reset),
        .clk_en      (clk_en),
        .seq_clear   (seq_clear),
        .event_in    (interrupt_status_group[g]),
        .status_read (isr_rd[g]),
        .req_bit     (irr[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.pin_sync = {st_reg.pin_sync[1:0], ext_reset_pin_n};
    case (st_reg.state)
      FPC_ST_IDLE:
      begin
        if (pin_rst || global_reset_cmd)
        begin
          st_next.state = FPC_ST_RUN;
          st_next.cnt   = '0;
          st_next.ctrl  = FPC_CTRL_DEF;
        end
        else if (ctrl_wr && host_req.wdata[FPC_BIT_RESET])
        begin
          // Defaults land with the start so no stale mode is decoded
          st_next.state = FPC_ST_RUN;
          st_next.cnt   = '0;
          st_next.ctrl  = FPC_CTRL_DEF;
        end
        else if (ctrl_wr)
          st_next.ctrl = host_req.wdata & FPC_CTRL_WMASK;
      end
      FPC_ST_RUN:
      begin
        // Writes during the sequence are dropped, not queued
        st_next.ctrl     = FPC_CTRL_DEF;
        st_next.drive_en = 1'b0;
        st_next.cnt      = st_reg.cnt + 12'h001;
        if (pin_rst)
          st_next.cnt = '0;
        else if (st_reg.cnt == FPC_RST_LAST)
        begin
          // Clear the count so it never passes the last value
          st_next.state = FPC_ST_IDLE;
          st_next.cnt   = '0;
        end
      end
      default:
        st_next.state = FPC_ST_RUN;
    endcase
    st_next.busy = st_next.state == FPC_ST_RUN;

    // Read data; reserved bits read zero, summary reads live state
    st_next.rdata = 8'h00;
    if (host_req.rd && host_req.addr == FPC_ADDR_CTRL)
      st_next.rdata = {st_next.busy, st_reg.ctrl[6:0]};
    else if (host_req.rd && host_req.addr == FPC_ADDR_IRR)
      st_next.rdata = irr;
    st_next.sclr = isr_rd;
    st_next.pio_dir = '0;

    // Decode mode for the framing synchronizer
    st_next.cfg = '0;
    st_next.cfg.t1_mode = t1;
    st_next.cfg.rx_framer_mode_sel = mode;
    st_next.cfg.loss_of_frame_thresholds = loss_of_frame_thresholds;
    if (t1)
    begin
      st_next.cfg.crc_fbit_include = st_reg.ctrl[FPC_BIT_INCF];
      case (mode)
        FPC_T1_SF:      st_next.cfg.t1_sf = 1'b1;
        FPC_T1_SF_JYA:
        begin
          st_next.cfg.t1_sf = 1'b1;
          st_next.cfg.japan_yellow_alarm = 1'b1;
        end
        FPC_T1_SF_DM:
        begin
          st_next.cfg.t1_sf = 1'b1;
          st_next.cfg.t1_dm = 1'b1;
        end
        FPC_T1_SLC_LOF:
        begin
          st_next.cfg.t1_slc = 1'b1;
          st_next.cfg.slc_frame_loss_option = 1'b1;
        end
        FPC_T1_SLC:     st_next.cfg.t1_slc = 1'b1;
        FPC_T1_ESF_FPS: st_next.cfg.t1_esf = 1'b1;
        FPC_T1_ESF_MIM:
        begin
          st_next.cfg.t1_esf = 1'b1;
          st_next.cfg.t1_esf_crc_check = 1'b1;
        end
        FPC_T1_ESF_FRC:
        begin
          st_next.cfg.t1_esf = 1'b1;
          st_next.cfg.t1_esf_crc_check = 1'b1;
          st_next.cfg.t1_esf_force_crc = 1'b1;
        end
        default: st_next.cfg.t1_sf = 1'b0;
      endcase
    end
    else
    begin
      // F-bit option forced low in E1
      st_next.cfg.crc_fbit_include = 1'b0;
      st_next.cfg.e1_cas_mf = mode[3];
      st_next.cfg.e1_crc_mf = mode[2];
      st_next.cfg.bit_slip_handling = mode[1];
    end

    // Interrupt summary only reaches the pin when enabled
    st_next.mflag = master_interrupt_enable && (|irr);
    st_next.irq_n = !st_next.mflag;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      // Power-up runs the sequence too
      st_reg       <= '0;
      st_reg.state <= FPC_ST_RUN;
      st_reg.busy  <= 1'b1;
      st_reg.irq_n <= 1'b1;
      st_reg.pin_sync <= 3'b111;
    end
    else if (clk_en)
      st_reg <= st_next;
  end

  // Programmable I/O direction is held at 0; no register reconfigures it
  assign pio_dir_out             = st_reg.pio_dir;
  // Line rate comes from the line clocks; only nominal rate is chosen
  assign framer_cfg              = st_reg.cfg;
  assign host_rdata              = st_reg.rdata;
  assign status_clear            = st_reg.sclr;
  assign framer_reset_active     = st_reg.busy;
  assign rx_signaling_out_oe     = st_reg.drive_en;
  assign rx_pcm_out_oe           = st_reg.drive_en;
  assign signaling_freeze_out_oe = st_reg.drive_en;
  assign master_interrupt_flag   = st_reg.mflag;
  assign irq_out_n               = st_reg.irq_n;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_start;
    st_reg.state == FPC_ST_IDLE && st_next.state == FPC_ST_RUN;
  endsequence

  a_reset_bit_busy: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && st_reg.state == FPC_ST_RUN |-> st_reg.busy)
    else $error("reset bit not busy during sequence");

  a_start_on_write: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && st_reg.state == FPC_ST_IDLE && ctrl_wr
      && host_req.wdata[FPC_BIT_RESET] |=> st_reg.busy)
    else $error("reset write did not start sequence");

  a_seq_bounded: assert property (
    @(posedge core_clk) disable iff (reset)
    st_reg.cnt <= FPC_RST_LAST)
    else $error("reset sequence too long");

  a_ctrl_default: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en and s_start) |=> st_reg.ctrl == FPC_CTRL_DEF)
    else $error("control not defaulted");

  a_outputs_float: assert property (
    @(posedge core_clk) disable iff (reset)
    st_reg.busy |-> !rx_pcm_out_oe && !rx_signaling_out_oe)
    else $error("system bus driven after reset");

  a_e1_ignore_fbit: assert property (
    @(posedge core_clk) disable iff (reset)
    !framer_cfg.t1_mode |-> !framer_cfg.crc_fbit_include)
    else $error("F-bit option active in E1");

  a_irq_enable: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && !master_interrupt_enable |=> irq_out_n)
    else $error("interrupt without enable");

  a_irq_or: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && master_interrupt_enable && (|irr) |=> !irq_out_n)
    else $error("interrupt pin missed request");

  a_reserved_zero: assert property (
    @(posedge core_clk) disable iff (reset)
    st_reg.ctrl[6] == 1'b0)
    else $error("reserved control bit set");

endmodule

/* testbench/fpc_host_model.sv */
// Host processor model driving the framer register port
`timescale 1ns/1ps
module fpc_host_model
(
  // Clock
  input  wire logic         core_clk,
  // Register port
  output fpc_pkg::fpc_req_t host_req,
  input  wire logic [7:0]   host_rdata
);
  import fpc_pkg::*;

  initial host_req = '0;

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge core_clk);
    host_req <= '0;
  endtask

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge core_clk);
    host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    host_req <= '0;
    #1 d = host_rdata;
  endtask

  // Reserved bit 6 always goes out as 0
  task automatic wr_ctrl(input logic [7:0] d);
    wr(FPC_ADDR_CTRL, d & 8'hbf);
  endtask

  // Polls the busy bit; no control write is made until it drops
  task automatic wait_idle(output int n);
    logic [7:0] d;
    n = 0;
    d = 8'h80;
    while (d[FPC_BIT_RESET] !== 1'b0 && n < 4000)
    begin
      rd(FPC_ADDR_CTRL, d);
      n += 2;
    end
  endtask

  // Service routine reads each flagged group once, then reads the summary back once
  task automatic drain(output logic [7:0] irr);
    logic [7:0] junk;
    rd(FPC_ADDR_IRR, irr);
    for (int i = 0; i < 8; i++)
      if (irr[i])
        rd(FPC_ADDR_ISR0 + 9'(i), junk);
    rd(FPC_ADDR_IRR, irr);
  endtask
endmodule

/* testbench/tb_top.sv */
// Testbench for the framer primary control and interrupt summary
`timescale 1ns/1ps
module tb_top;
  import fpc_pkg::*;

  logic       core_clk, reset, clk_en, ext_reset_pin_n, global_reset_cmd;
  logic [7:0] interrupt_status_group, host_rdata, status_clear, pio_dir_out;
  logic       master_interrupt_enable, framer_reset_active;
  logic [3:0] loss_of_frame_thresholds;
  logic       oe_sig, oe_pcm, oe_frz, master_interrupt_flag, irq_out_n;
  fpc_req_t   host_req;
  fpc_cfg_t   framer_cfg;
  int         n_mismatch, cmp_count, cyc, n;
  logic [7:0] d, c;
  logic [3:0] t1_codes [10] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9,
                                4'hc, 4'hd, 4'h2};

  fpc_top i_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .ext_reset_pin_n(ext_reset_pin_n), .global_reset_cmd(global_reset_cmd),
    .host_req(host_req), .host_rdata(host_rdata),
    .interrupt_status_group(interrupt_status_group),
    .master_interrupt_enable(master_interrupt_enable),
    .loss_of_frame_thresholds(loss_of_frame_thresholds),
    .status_clear(status_clear), .framer_cfg(framer_cfg),
    .framer_reset_active(framer_reset_active),
    .rx_signaling_out_oe(oe_sig), .rx_pcm_out_oe(oe_pcm),
    .signaling_freeze_out_oe(oe_frz), .pio_dir_out(pio_dir_out),
    .master_interrupt_flag(master_interrupt_flag), .irq_out_n(irq_out_n));

  fpc_host_model u_host (.core_clk(core_clk), .host_req(host_req),
    .host_rdata(host_rdata));

  always #2.5 core_clk = ~core_clk;

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("counts: compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic fpc_cfg_t exp_cfg(input logic [7:0] v,
                                       input logic [3:0] l);
    fpc_cfg_t e;
    logic [3:0] m;
    e = '0;
    m = v[4:1];
    e.t1_mode = v[0];
    e.crc_fbit_include = v[5] & v[0];
    e.rx_framer_mode_sel = m;
    e.loss_of_frame_thresholds = l;
    if (!v[0])
    begin
      e.e1_cas_mf = m[3];
      e.e1_crc_mf = m[2];
      e.bit_slip_handling = m[1];
    end
    else
    begin
      e.t1_sf = m inside {4'h4, 4'h5, 4'h6};
      e.t1_esf = m inside {4'h1, 4'hc, 4'hd};
      e.t1_esf_crc_check = m inside {4'hc, 4'hd};
      e.t1_esf_force_crc = (m == 4'hd);
      e.t1_slc = m inside {4'h8, 4'h9};
      e.slc_frame_loss_option = (m == 4'h8);
      e.japan_yellow_alarm = (m == 4'h5);
      e.t1_dm = (m == 4'h6);
    end
    return e;
  endfunction

  // Cause 0 is a host write, 1 the global command, 2 the reset pin
  task automatic run_seq(input int cause);
    u_host.wr_ctrl(8'h3f);
    if (cause == 0)
      u_host.wr_ctrl(8'h80);
    @(posedge core_clk);
    global_reset_cmd <= (cause == 1);
    ext_reset_pin_n <= (cause != 2);
    @(posedge core_clk);
    global_reset_cmd <= 1'b0;
    repeat (6) @(posedge core_clk);
    ext_reset_pin_n <= 1'b1;
    #1 chk(framer_reset_active, 1);
    u_host.rd(FPC_ADDR_CTRL, d);
    chk(d, 8'h80);
    u_host.wait_idle(n);
    chk(n <= 3012, 1);
    u_host.rd(FPC_ADDR_CTRL, d);
    chk(d, FPC_CTRL_DEF);
    chk(framer_cfg, exp_cfg(8'h00, loss_of_frame_thresholds));
    chk({oe_sig, oe_pcm, oe_frz, pio_dir_out}, 0);
    $display("test reset_cause_%0d done", cause);
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(67));
    core_clk = 0;
    reset = 1;
    clk_en = 1;
    ext_reset_pin_n = 1;
    global_reset_cmd = 0;
    interrupt_status_group = 0;
    master_interrupt_enable = 1;
    loss_of_frame_thresholds = 0;
    repeat (6) @(posedge core_clk);
    chk(framer_reset_active, 1);
    chk({oe_sig, oe_pcm, oe_frz, irq_out_n}, 4'b0001);
    reset <= 1'b0;
    u_host.wait_idle(n);
    chk(n <= 3012, 1);
    chk(pio_dir_out, 8'h00);
    $display("test power_up done");
    for (int i = 0; i < 26; i++)
    begin
      c = (i < 16) ? {3'b000, 4'(i), 1'b0} : {3'b000, t1_codes[i - 16], 1'b1};
      c[5] = 1'($urandom);
      @(posedge core_clk);
      loss_of_frame_thresholds <= 4'($urandom);
      u_host.wr_ctrl(c);
      u_host.rd(FPC_ADDR_CTRL, d);
      chk(d, c);
      chk(framer_cfg, exp_cfg(c, loss_of_frame_thresholds));
    end
    $display("test modes done");
    for (int k = 0; k < 3; k++)
      run_seq(k);
    for (int g = 0; g < FPC_NGRP; g++)
    begin
      @(posedge core_clk);
      master_interrupt_enable <= 1'b0;
      interrupt_status_group <= 8'h01 << g;
      @(posedge core_clk);
      interrupt_status_group <= 8'h00;
      repeat (3) @(posedge core_clk);
      #1 chk({master_interrupt_flag, irq_out_n}, 2'b01);
      @(posedge core_clk);
      master_interrupt_enable <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 chk({master_interrupt_flag, irq_out_n}, 2'b10);
      u_host.wr(FPC_ADDR_IRR, 8'h00);
      u_host.rd(FPC_ADDR_IRR, d);
      chk(d, 8'h01 << g);
      u_host.rd(FPC_ADDR_ISR0 + 9'(g), d);
      chk(status_clear, 8'h01 << g);
      repeat (2) @(posedge core_clk);
      #1 chk(irq_out_n, 1);
      u_host.drain(d);
      chk(d, 8'h00);
    end
    $display("test interrupts done");
    tally_and_finish();
  end
endmodule
